// >>> hw/ctp_pulse_bank.sv
// Custom transmit pulse magnitude register bank with pulse source selection
// Function
// RQ1 - Phase one code from first register
// RQ2 - Phase two code from second register
// RQ3 - Phase three code from third register
// RQ4 - Phase four code from fourth register
// RQ5 - Custom codes used only when select high
// RQ6 - Codes unsigned, larger means larger amplitude
// RQ7 - Software writes zero to reserved top bit
// RQ8 - Select low uses internal template magnitudes
// RQ9 - Registers read back, codes presented continuously
`timescale 1ns/1ps
`default_nettype none
module ctp_pulse_bank (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic [6:0] templateMag1,
	input wire logic [6:0] templateMag2,
	input wire logic [6:0] templateMag3,
	input wire logic [6:0] templateMag4,
	output logic customPulseSelect,
	output logic [6:0] phaseMagnitude1,
	output logic [6:0] phaseMagnitude2,
	output logic [6:0] phaseMagnitude3,
	output logic [6:0] phaseMagnitude4
);
	logic [7:0] word1;
	logic [7:0] word2;
	logic [7:0] word3;
	logic [7:0] word4;
	logic [7:0] enable_q;
	logic [7:0] enable_d;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic [6:0] mag1_q;
	logic [6:0] mag1_d;
	logic [6:0] mag2_q;
	logic [6:0] mag2_d;
	logic [6:0] mag3_q;
	logic [6:0] mag3_d;
	logic [6:0] mag4_q;
	logic [6:0] mag4_d;
	logic sel_q;
	logic sel_d;
	logic wrEnable;
	logic wrPhase1;
	logic wrPhase2;
	logic wrPhase3;
	logic wrPhase4;

	// Write strobe decode, one per register
	always_comb begin
		wrEnable = 1'b0;
		wrPhase1 = 1'b0;
		wrPhase2 = 1'b0;
		wrPhase3 = 1'b0;
		wrPhase4 = 1'b0;
		if (regWr) begin
			case (regAddr)
				ctp_pkg::ADDR_PULSE_ENABLE: wrEnable = 1'b1;
				ctp_pkg::ADDR_PHASE1: wrPhase1 = 1'b1;
				ctp_pkg::ADDR_PHASE2: wrPhase2 = 1'b1;
				ctp_pkg::ADDR_PHASE3: wrPhase3 = 1'b1;
				ctp_pkg::ADDR_PHASE4: wrPhase4 = 1'b1;
				default: wrEnable = 1'b0;
			endcase
		end
	end

	// Four phase magnitude words
	ctp_word_reg uWord1 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wrEn(wrPhase1),
		.wrData(regWrData),
		.value(word1)
	);
	ctp_word_reg uWord2 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wrEn(wrPhase2),
		.wrData(regWrData),
		.value(word2)
	);
	ctp_word_reg uWord3 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wrEn(wrPhase3),
		.wrData(regWrData),
		.value(word3)
	);
	ctp_word_reg uWord4 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wrEn(wrPhase4),
		.wrData(regWrData),
		.value(word4)
	);

	// Pulse source control register, only the select bit is used
	always_comb begin
		enable_d = enable_q;
		if (wrEnable) begin
			enable_d = regWrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			enable_q <= ctp_pkg::ENABLE_RESET;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Read data stands one cycle, zero otherwise
	always_comb begin
		rdData_d = ctp_pkg::UNMAPPED_READ;
		if (regRd) begin
			case (regAddr)
				ctp_pkg::ADDR_PULSE_ENABLE: rdData_d = enable_q;
				ctp_pkg::ADDR_PHASE1: rdData_d = word1; // RQ9
				ctp_pkg::ADDR_PHASE2: rdData_d = word2; // RQ9
				ctp_pkg::ADDR_PHASE3: rdData_d = word3; // RQ9
				ctp_pkg::ADDR_PHASE4: rdData_d = word4; // RQ9
				default: rdData_d = ctp_pkg::UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rdData_q <= ctp_pkg::UNMAPPED_READ;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	// Registered copy of the select bit
	always_comb begin
		sel_d = enable_q[ctp_pkg::SELECT_BIT]; // RQ5
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sel_q <= ctp_pkg::ENABLE_RESET[ctp_pkg::SELECT_BIT];
		end else begin
			sel_q <= sel_d;
		end
	end

	// Phase one source; top bit of the word is not used
	always_comb begin
		mag1_d = templateMag1; // RQ8
		if (enable_q[ctp_pkg::SELECT_BIT]) begin // RQ5
			mag1_d = word1[6:0]; // RQ1 RQ6
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mag1_q <= ctp_pkg::PHASE_RESET[6:0];
		end else begin
			mag1_q <= mag1_d; // RQ9
		end
	end

	// Phase two source
	always_comb begin
		mag2_d = templateMag2; // RQ8
		if (enable_q[ctp_pkg::SELECT_BIT]) begin // RQ5
			mag2_d = word2[6:0]; // RQ2
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mag2_q <= ctp_pkg::PHASE_RESET[6:0];
		end else begin
			mag2_q <= mag2_d; // RQ9
		end
	end

	// Phase three source
	always_comb begin
		mag3_d = templateMag3; // RQ8
		if (enable_q[ctp_pkg::SELECT_BIT]) begin // RQ5
			mag3_d = word3[6:0]; // RQ3
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mag3_q <= ctp_pkg::PHASE_RESET[6:0];
		end else begin
			mag3_q <= mag3_d; // RQ9
		end
	end

	// Phase four source
	always_comb begin
		mag4_d = templateMag4; // RQ8
		if (enable_q[ctp_pkg::SELECT_BIT]) begin // RQ5
			mag4_d = word4[6:0]; // RQ4
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mag4_q <= ctp_pkg::PHASE_RESET[6:0];
		end else begin
			mag4_q <= mag4_d; // RQ9
		end
	end

	assign regRdData = rdData_q;
	assign customPulseSelect = sel_q;
	assign phaseMagnitude1 = mag1_q;
	assign phaseMagnitude2 = mag2_q;
	assign phaseMagnitude3 = mag3_q;
	assign phaseMagnitude4 = mag4_q;
endmodule // ctp_pulse_bank
`default_nettype wire

// >>> hw/ctp_pkg.sv
// Package with offsets, field layouts and reset values of the custom pulse bank
package ctp_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int MAG_W = 7;
	localparam int NUM_PHASES = 4;
	localparam logic [4:0] ADDR_PULSE_ENABLE = 5'h11;
	localparam logic [4:0] ADDR_PHASE1 = 5'h1C;
	localparam logic [4:0] ADDR_PHASE2 = 5'h1D;
	localparam logic [4:0] ADDR_PHASE3 = 5'h1E;
	localparam logic [4:0] ADDR_PHASE4 = 5'h1F;
	localparam int SELECT_BIT = 3;
	localparam int RSV_BIT = 7;
	localparam logic [7:0] PHASE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// Phase step sequence for mark generation
	typedef enum logic [1:0] {
		PH_FIRST,
		PH_SECOND,
		PH_THIRD,
		PH_FOURTH
	} ctp_phase_t;
endpackage

// >>> hw/ctp_word_reg.sv
// One 8-bit software-written pulse magnitude register
`timescale 1ns/1ps
`default_nettype none
module ctp_word_reg (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	output logic [7:0] value
);
	logic [7:0] word_q;
	logic [7:0] word_d;

	always_comb begin
		word_d = word_q;
		if (wrEn) begin
			word_d = wrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			word_q <= ctp_pkg::PHASE_RESET;
		end else begin
			word_q <= word_d;
		end
	end

	assign value = word_q;
endmodule // ctp_word_reg
`default_nettype wire

// >>> test/ctp_bank_assertions.sv
// Port assertions for the pulse bank
`timescale 1ns/1ps
`default_nettype none
module ctp_bank_assertions (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic [6:0] templateMag1,
	input wire logic customPulseSelect,
	input wire logic [6:0] phaseMagnitude1,
	input wire logic [6:0] phaseMagnitude2,
	input wire logic [6:0] phaseMagnitude3,
	input wire logic [6:0] phaseMagnitude4
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
logic [4:0] a1;
logic [4:0] a2;
logic [7:0] d1;
logic [7:0] d2;
// Write address and data two edges back
always_ff @(posedge sys_clk) begin
	a1 <= (nrst && regWr) ? regAddr : 5'h00;
	a2 <= nrst ? a1 : 5'h00;
	d1 <= regWrData;
	d2 <= d1;
end
property p_ph1; a2==5'h1C && customPulseSelect |-> phaseMagnitude1==d2[6:0]; endproperty
a_ph1: assert property (p_ph1) else $error("ph1");
property p_ph2; a2==5'h1D && customPulseSelect |-> phaseMagnitude2==d2[6:0]; endproperty
a_ph2: assert property (p_ph2) else $error("ph2");
property p_ph3; a2==5'h1E && customPulseSelect |-> phaseMagnitude3==d2[6:0]; endproperty
a_ph3: assert property (p_ph3) else $error("ph3");
property p_ph4; a2==5'h1F && customPulseSelect |-> phaseMagnitude4==d2[6:0]; endproperty
a_ph4: assert property (p_ph4) else $error("ph4");
property p_sel; a2==5'h11 |-> customPulseSelect==d2[3]; endproperty
a_sel: assert property (p_sel) else $error("sel");
property p_tpl; $past(nrst) && !customPulseSelect |-> phaseMagnitude1==$past(templateMag1);
endproperty
a_tpl: assert property (p_tpl) else $error("tpl");
property p_rd; regRd && regAddr==5'h1C ##1 customPulseSelect |-> regRdData[6:0]==phaseMagnitude1;
endproperty
a_rd: assert property (p_rd) else $error("rd");
property p_idle; !$past(regRd) |-> regRdData==8'h00; endproperty
a_idle: assert property (p_idle) else $error("idle");
endmodule // ctp_bank_assertions
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the pulse bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin nCompared++; if ((s)!==(e)) begin nErrors++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
logic sys_clk = 1'b0;
logic nrst = 1'b0;
logic regWr = 1'b0;
logic regRd = 1'b0;
logic [4:0] regAddr = 5'h00;
logic [7:0] regWrData = 8'h00;
logic [7:0] regRdData;
logic [6:0] templateMag1 = 7'h11, templateMag2 = 7'h22, templateMag3 = 7'h33, templateMag4 = 7'h44;
logic customPulseSelect;
logic [6:0] phaseMagnitude1, phaseMagnitude2, phaseMagnitude3, phaseMagnitude4;
int nErrors = 0;
int nCompared = 0;
int cycles = 0;
always #5 sys_clk = ~sys_clk;
ctp_pulse_bank dut (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData),
	.templateMag1(templateMag1),
	.templateMag2(templateMag2),
	.templateMag3(templateMag3),
	.templateMag4(templateMag4),
	.customPulseSelect(customPulseSelect),
	.phaseMagnitude1(phaseMagnitude1),
	.phaseMagnitude2(phaseMagnitude2),
	.phaseMagnitude3(phaseMagnitude3),
	.phaseMagnitude4(phaseMagnitude4)
);
task wrapUp;
	if (nErrors == 0 && nCompared > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
always @(posedge sys_clk) begin
	cycles++;
	if (cycles == 400) begin
		nErrors++;
		wrapUp;
	end
end
task wr(input logic [4:0] a, input logic [7:0] d);
	regAddr <= a;
	regWrData <= d;
	regWr <= 1'b1;
	@(posedge sys_clk);
	regWr <= 1'b0;
	@(posedge sys_clk);
endtask
task rd(input logic [4:0] a, input logic [7:0] e);
	regAddr <= a;
	regRd <= 1'b1;
	@(posedge sys_clk);
	regRd <= 1'b0;
	#1;
	`CHK("read", e, regRdData)
	@(posedge sys_clk);
endtask
task ph(input logic s, input logic [6:0] a, b, c, d);
	@(posedge sys_clk);
	#1;
	`CHK("sel", s, customPulseSelect)
	`CHK("mag1", a, phaseMagnitude1)
	`CHK("mag2", b, phaseMagnitude2)
	`CHK("mag3", c, phaseMagnitude3)
	`CHK("mag4", d, phaseMagnitude4)
	@(posedge sys_clk);
endtask
task afterReset;
	ph(1'b0, 7'h11, 7'h22, 7'h33, 7'h44);
	rd(5'h1C, 8'h00);
	wr(5'h12, 8'hFF);
	rd(5'h12, 8'h00);
endtask
task customCodes;
	wr(5'h11, 8'h08);
	wr(5'h1C, 8'h7F);
	wr(5'h1D, 8'h40);
	wr(5'h1E, 8'h01);
	wr(5'h1F, 8'h5A);
	ph(1'b1, 7'h7F, 7'h40, 7'h01, 7'h5A);
	rd(5'h1D, 8'h40);
	rd(5'h1C, 8'h7F);
	rd(5'h1E, 8'h01);
	rd(5'h1F, 8'h5A);
endtask
task selectOff;
	wr(5'h11, 8'hF7);
	templateMag3 <= 7'h0C;
	ph(1'b0, 7'h11, 7'h22, 7'h0C, 7'h44);
	rd(5'h11, 8'hF7);
endtask
initial begin
	repeat (5) @(posedge sys_clk);
	nrst <= 1'b1;
	afterReset;
	customCodes;
	selectOff;
	wrapUp;
end
endmodule // tb_top
bind ctp_pulse_bank ctp_bank_assertions chk (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData),
	.templateMag1(templateMag1),
	.customPulseSelect(customPulseSelect),
	.phaseMagnitude1(phaseMagnitude1),
	.phaseMagnitude2(phaseMagnitude2),
	.phaseMagnitude3(phaseMagnitude3),
	.phaseMagnitude4(phaseMagnitude4)
);
`default_nettype wire
